// *** rtl/cdpm_pkg.sv ***
// cdpm package: constants, modes and carriers for the clock and power monitor
package cdpm_pkg;

  // ----------------------------------------------------------------
  // clock division figures
  // ----------------------------------------------------------------
  localparam int unsigned CLKOUT_DIV     = 6;
  localparam int unsigned CLKOUT_HALF    = CLKOUT_DIV / 2;
  localparam int unsigned CYC_PER_MC     = 6;
  localparam int unsigned CYC_PER_MC_CMP = 12;
  localparam logic [7:0]  DIVIDER_RST    = 8'h00;

  // ----------------------------------------------------------------
  // oscillator stabilisation counts
  // ----------------------------------------------------------------
  localparam int unsigned STAB_XTAL      = 1024;
  localparam int unsigned STAB_RC        = 256;
  localparam int unsigned STAB_W         = 11;

  // ----------------------------------------------------------------
  // brownout thresholds, millivolts
  // ----------------------------------------------------------------
  localparam int unsigned BO_LOW_MV      = 2500;
  localparam int unsigned BO_HIGH_MV     = 3800;

  // ----------------------------------------------------------------
  // power control bit positions
  // ----------------------------------------------------------------
  localparam int unsigned PWR_SLEEP_BIT  = 0;
  localparam int unsigned PWR_DEEP_BIT   = 1;
  localparam int unsigned PWR_PU_FLAG_BIT = 4;
  localparam int unsigned PWR_BO_FLAG_BIT = 5;

  typedef enum logic [1:0] {
    CDPM_OSC_XTAL,
    CDPM_OSC_RC,
    CDPM_OSC_EXT
  } cdpm_osc_t;

  typedef enum logic [1:0] {
    CDPM_RUN,
    CDPM_IDLE,
    CDPM_DOWN,
    CDPM_WAKE
  } cdpm_mode_t;

  // fixed configuration word
  typedef struct packed {
    cdpm_osc_t  osc_sel;
    logic       compat_clock_halve;
    logic       brownout_level;
  } cdpm_user_config_word_t;

  // software-driven control bits
  typedef struct packed {
    logic       clkout_enable;
    logic       brownout_irq_select;
    logic       brownout_disable;
    logic       global_irq_on;
    logic       brownout_irq_enable;
  } cdpm_ctrl_t;

endpackage

// *** rtl/cdpm_divider.sv ***
// cdpm divider: programmable divide-by-2*(N+1) tick generator, N zero passes source ticks through
`timescale 1ns/1ps
`default_nettype none
module cdpm_divider #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         src_tick,
  input  wire logic [W-1:0] div_n,
  output logic              tick
);

  logic [W:0] cnt_r;
  logic [W:0] cnt_nxt;
  logic       tick_nxt;
  logic [W:0] limit;

  // ----------------------------------------------------------------
  // count source ticks, wrap at 2*(N+1)-1
  // ----------------------------------------------------------------
  always_comb begin
    limit    = {div_n, 1'b1};
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (div_n == '0) begin
      cnt_nxt  = '0;
      tick_nxt = src_tick;
    end else if (src_tick) begin
      // live value compared at once, the period in progress ends at the new limit
      if (cnt_r >= limit) begin
        cnt_nxt  = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end

endmodule
`default_nettype wire

// *** rtl/cdpm_core.sv ***
// cdpm core: clock output, cpu clock division, brownout, power-on and sleep control
`timescale 1ns/1ps
`default_nettype none
// Function
// - clock output toggles at one third of cpu clock rate
// - clock output only with rc or external clock, enabled, running in idle
// - external clock, clock output not enabled: second oscillator pin is ordinary port pin
// - compat halve divides cpu clock by two, twelve clocks per machine cycle
// - divider zero gives oscillator clock, or halved under compat halve
// - divider N from 1 to 255 divides by 2*(N+1)
// - divider writes accepted any time without disturbing execution
// - brownout resets by default, raises interrupt when irq select set
// - brownout reset held while detector stays active
// - brownout interrupt raised once on inactive-to-active edge only
// - brownout interrupt output ignores global enable and brownout enable, only its wake needs both
// - every brownout sets brownout flag until software writes zero
// - brownout level one selects 2.5 V, zero selects 3.8 V
// - brownout disable stops detector: no reset, no interrupt
// - power-up detection sets powerup flag until software clears it
// - sleep request enters idle, ended by enabled interrupt or reset
// - deep sleep request enters power-down and stops oscillator
// - power-down ends on reset or enabled higher-priority wake interrupt
// - enabled brownout interrupt wakes power-down; brownout reset acts immediately
// - wake restarts oscillator, run after 1024 crystal or 256 rc clocks
// - watchdog reset, brownout and comparator keep working in power-down
// - brownout flag set by brownout reset or interrupt and at power-on
// - deep sleep request is power control bit one, one enters power-down
module cdpm_core (
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire cdpm_pkg::cdpm_user_config_word_t user_config_word,
  input  wire cdpm_pkg::cdpm_ctrl_t            ctrl,
  input  wire logic [7:0]                      cpu_divider_reg,
  input  wire logic                            power_wr,
  input  wire logic [7:0]                      power_wdata,
  input  wire logic                            bo_detect_pin,
  input  wire logic                            por_detect_pin,
  input  wire logic                            wdt_overflow,
  input  wire logic                            wake_irq,
  input  wire logic                            any_irq,
  input  wire logic                            gpio_out,
  input  wire logic                            gpio_oe,
  output logic                                 osc_out_pin_o,
  output logic                                 osc_out_pin_oe,
  output logic                                 osc_run,
  output logic                                 cpu_tick,
  output logic                                 periph_tick,
  output logic                                 cpu_reset,
  output logic                                 brownout_irq,
  output logic                                 brownout_level_sel,
  output logic [7:0]                           power_control_reg
);

  // ----------------------------------------------------------------
  // synchronisers for pin-level detector inputs
  // ----------------------------------------------------------------
  logic [1:0] bo_sync_r;
  logic [1:0] por_sync_r;
  logic       bo_d_r;
  logic       por_d_r;
  logic       bo_active;
  logic       bo_rise;
  logic       por_rise;
  logic       bo_as_reset;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bo_sync_r  <= 2'b00;
      por_sync_r <= 2'b00;
      bo_d_r     <= 1'b0;
      por_d_r    <= 1'b0;
    end else begin
      bo_sync_r  <= {bo_sync_r[0], bo_detect_pin};
      por_sync_r <= {por_sync_r[0], por_detect_pin};
      bo_d_r     <= bo_active;
      por_d_r    <= por_sync_r[1];
    end
  end

  // detector keeps running in power-down, the oscillator does not matter here
  assign bo_active   = bo_sync_r[1] & ~ctrl.brownout_disable;
  assign bo_rise     = bo_active & ~bo_d_r;
  assign por_rise    = por_sync_r[1] & ~por_d_r;
  assign bo_as_reset = ~ctrl.brownout_irq_select;

  // analog comparator threshold select passes straight to the detector
  assign brownout_level_sel = user_config_word.brownout_level;

  // ----------------------------------------------------------------
  // mode machine and power control bits
  // ----------------------------------------------------------------
  cdpm_pkg::cdpm_mode_t mode_r;
  cdpm_pkg::cdpm_mode_t mode_nxt;
  logic                 sleep_r;
  logic                 sleep_nxt;
  logic                 deep_r;
  logic                 deep_nxt;
  logic                 bo_flag_r;
  logic                 bo_flag_nxt;
  logic                 pu_flag_r;
  logic                 pu_flag_nxt;
  logic [cdpm_pkg::STAB_W-1:0] stab_r;
  logic [cdpm_pkg::STAB_W-1:0] stab_nxt;
  logic [cdpm_pkg::STAB_W-1:0] stab_limit;
  logic                 bo_irq_req;
  logic                 wake_ev;

  assign bo_irq_req = bo_rise & ctrl.brownout_irq_select
                      & ctrl.global_irq_on & ctrl.brownout_irq_enable;
  assign wake_ev    = wake_irq | bo_irq_req;
  assign stab_limit = (user_config_word.osc_sel == cdpm_pkg::CDPM_OSC_XTAL)
                      ? cdpm_pkg::STAB_W'(cdpm_pkg::STAB_XTAL - 1)
                      : cdpm_pkg::STAB_W'(cdpm_pkg::STAB_RC - 1);

  always_comb begin
    mode_nxt  = mode_r;
    sleep_nxt = sleep_r;
    deep_nxt  = deep_r;
    bo_flag_nxt = bo_flag_r;
    pu_flag_nxt = pu_flag_r;
    stab_nxt  = stab_r;
    if (power_wr) begin
      sleep_nxt = power_wdata[cdpm_pkg::PWR_SLEEP_BIT];
      deep_nxt  = power_wdata[cdpm_pkg::PWR_DEEP_BIT];
      bo_flag_nxt = bo_flag_r & power_wdata[cdpm_pkg::PWR_BO_FLAG_BIT];
      pu_flag_nxt = pu_flag_r & power_wdata[cdpm_pkg::PWR_PU_FLAG_BIT];
    end
    // set wins over a software clear in the same cycle
    if (bo_rise) begin
      bo_flag_nxt = 1'b1;
    end
    if (por_rise) begin
      bo_flag_nxt = 1'b1;
      pu_flag_nxt = 1'b1;
    end
    unique case (mode_r)
      cdpm_pkg::CDPM_RUN: begin
        if (deep_nxt) begin
          mode_nxt = cdpm_pkg::CDPM_DOWN;
        end else if (sleep_nxt) begin
          mode_nxt = cdpm_pkg::CDPM_IDLE;
        end
      end
      cdpm_pkg::CDPM_IDLE: begin
        if (any_irq | bo_irq_req) begin
          mode_nxt  = cdpm_pkg::CDPM_RUN;
          sleep_nxt = 1'b0;
        end
      end
      cdpm_pkg::CDPM_DOWN: begin
        if (wake_ev) begin
          mode_nxt = cdpm_pkg::CDPM_WAKE;
          stab_nxt = '0;
        end
      end
      cdpm_pkg::CDPM_WAKE: begin
        if (stab_r >= stab_limit) begin
          mode_nxt  = cdpm_pkg::CDPM_RUN;
          deep_nxt  = 1'b0;
          sleep_nxt = 1'b0;
        end else begin
          stab_nxt = stab_r + 1'b1;
        end
      end
    endcase
  end

  // reset clears the requests, which also ends any low-power mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r  <= cdpm_pkg::CDPM_RUN;
      sleep_r <= 1'b0;
      deep_r  <= 1'b0;
      bo_flag_r <= 1'b0;
      pu_flag_r <= 1'b0;
      stab_r  <= '0;
    end else begin
      mode_r  <= mode_nxt;
      sleep_r <= sleep_nxt;
      deep_r  <= deep_nxt;
      bo_flag_r <= bo_flag_nxt;
      pu_flag_r <= pu_flag_nxt;
      stab_r  <= stab_nxt;
    end
  end

  always_comb begin
    power_control_reg = 8'h00;
    power_control_reg[cdpm_pkg::PWR_SLEEP_BIT] = sleep_r;
    power_control_reg[cdpm_pkg::PWR_DEEP_BIT]  = deep_r;
    power_control_reg[cdpm_pkg::PWR_PU_FLAG_BIT] = pu_flag_r;
    power_control_reg[cdpm_pkg::PWR_BO_FLAG_BIT] = bo_flag_r;
  end

  // ----------------------------------------------------------------
  // resets and interrupt
  // ----------------------------------------------------------------
  logic bo_irq_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bo_irq_r <= 1'b0;
    end else begin
      bo_irq_r <= bo_rise & ctrl.brownout_irq_select;
    end
  end

  assign brownout_irq = bo_irq_r;
  // combinational so it acts even with the oscillator stopped
  assign cpu_reset    = (bo_active & bo_as_reset) | wdt_overflow;

  // ----------------------------------------------------------------
  // cpu clock chain
  // ----------------------------------------------------------------
  logic half_r;
  logic src_tick;
  logic div_tick;

  assign osc_run = (mode_r != cdpm_pkg::CDPM_DOWN);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_r <= 1'b0;
    end else begin
      half_r <= osc_run & ~half_r;
    end
  end

  // halving trades speed for legacy twelve-clock machine cycles
  assign src_tick = user_config_word.compat_clock_halve ? half_r : osc_run;

  // divider samples the live value, so writes never stall the cpu
  cdpm_divider #(
    .W (8)
  ) u_div (
    .clk      (clk),
    .rst      (rst),
    .src_tick (src_tick),
    .div_n    (cpu_divider_reg),
    .tick     (div_tick)
  );

  assign periph_tick = div_tick;
  assign cpu_tick    = div_tick & (mode_r == cdpm_pkg::CDPM_RUN);

  // ----------------------------------------------------------------
  // clock output: toggles every three cpu clocks
  // ----------------------------------------------------------------
  logic [1:0] co_cnt_r;
  logic [1:0] co_cnt_nxt;
  logic       co_r;
  logic       co_nxt;
  logic       co_allowed;

  assign co_allowed = ctrl.clkout_enable
                      & (user_config_word.osc_sel != cdpm_pkg::CDPM_OSC_XTAL);

  always_comb begin
    co_cnt_nxt = co_cnt_r;
    co_nxt     = co_r;
    if (!co_allowed) begin
      co_cnt_nxt = 2'h0;
      co_nxt     = 1'b0;
    end else if (div_tick) begin
      if (co_cnt_r == 2'(cdpm_pkg::CLKOUT_HALF - 1)) begin
        co_cnt_nxt = 2'h0;
        co_nxt     = ~co_r;
      end else begin
        co_cnt_nxt = co_cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      co_cnt_r <= 2'h0;
      co_r     <= 1'b0;
    end else begin
      co_cnt_r <= co_cnt_nxt;
      co_r     <= co_nxt;
    end
  end

  // pin shared with port: only ext-clock frees it as gpio
  always_comb begin
    osc_out_pin_o  = 1'b0;
    osc_out_pin_oe = 1'b0;
    if (co_allowed) begin
      osc_out_pin_o  = co_r;
      osc_out_pin_oe = 1'b1;
    end else if (user_config_word.osc_sel == cdpm_pkg::CDPM_OSC_EXT) begin
      osc_out_pin_o  = gpio_out;
      osc_out_pin_oe = gpio_oe;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_bo_reset_hold: assert property (@(posedge clk) disable iff (rst)
    (bo_active && !ctrl.brownout_irq_select) |-> cpu_reset)
    else $error("brownout reset not held");

  a_bo_irq_once: assert property (@(posedge clk) disable iff (rst)
    brownout_irq |=> !brownout_irq)
    else $error("brownout irq repeated");

  a_bo_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    (bo_flag_r && !power_wr) |=> bo_flag_r)
    else $error("brownout flag lost");

  a_bo_flag_set: assert property (@(posedge clk) disable iff (rst)
    bo_rise |=> bo_flag_r)
    else $error("brownout flag not set");

  a_pu_flag_set: assert property (@(posedge clk) disable iff (rst)
    por_rise |=> (pu_flag_r && bo_flag_r))
    else $error("power-up flags not set");

  a_down_osc_off: assert property (@(posedge clk) disable iff (rst)
    (mode_r == cdpm_pkg::CDPM_DOWN) |-> (!osc_run && !cpu_tick))
    else $error("oscillator runs in power-down");

  a_idle_gate: assert property (@(posedge clk) disable iff (rst)
    (mode_r == cdpm_pkg::CDPM_IDLE) |-> !cpu_tick)
    else $error("cpu clock in idle");

  a_wake_rc_len: assert property (@(posedge clk) disable iff (rst)
    ($rose(mode_r == cdpm_pkg::CDPM_WAKE)
      && user_config_word.osc_sel != cdpm_pkg::CDPM_OSC_XTAL)
    |-> (mode_r == cdpm_pkg::CDPM_WAKE) [*8])
    else $error("wake ended too early");

  a_wake_clears: assert property (@(posedge clk) disable iff (rst)
    ($past(mode_r) == cdpm_pkg::CDPM_WAKE && mode_r == cdpm_pkg::CDPM_RUN)
    |-> !deep_r)
    else $error("deep sleep request not cleared");

  a_bo_disable: assert property (@(posedge clk) disable iff (rst)
    (ctrl.brownout_disable && !wdt_overflow) |-> !cpu_reset)
    else $error("detector active while disabled");

endmodule
`default_nettype wire

// *** verification/cdpm_far_side.sv ***
// far-side model: device timing itself from the clock output pin
`timescale 1ns/1ps
`default_nettype none
module cdpm_far_side (
  input  wire logic        clk,
  input  wire logic        drive_o,
  input  wire logic        drive_oe,
  output wire logic        pin,
  output logic [15:0]      period
);
  logic        last_r = 1'b0;
  logic        prev_r = 1'b0;
  logic [15:0] cnt_r  = 16'h0000;
  // released pin: inverse of last level, so a stale copy never passes
  assign pin = drive_oe ? drive_o : ~last_r;
  always_ff @(posedge clk) begin
    if (drive_oe) begin
      last_r <= drive_o;
    end
    prev_r <= pin;
    cnt_r  <= (pin && !prev_r) ? 16'h0001 : cnt_r + 16'h0001;
    if (pin && !prev_r) begin
      period <= cnt_r;
    end
  end
endmodule
`default_nettype wire

// *** verification/clock_divider_power_monitor_tb.sv ***
// testbench for the clock and power monitor core
`timescale 1ns/1ps
`default_nettype none
module clock_divider_power_monitor_tb;
  logic                            clk = 1'b0;
  logic                            rst = 1'b1;
  cdpm_pkg::cdpm_user_config_word_t cfg;
  cdpm_pkg::cdpm_ctrl_t            ctl;
  logic [7:0]                      div = 8'h00;
  logic                            pwr_wr = 1'b0;
  logic [7:0]                      pwr_wd = 8'h00;
  logic                            bo = 1'b0;
  logic                            por = 1'b0;
  logic                            wdt = 1'b0;
  logic                            wake = 1'b0;
  logic                            anyi = 1'b0;
  logic                            gout = 1'b0;
  logic                            goe = 1'b0;
  logic                            pin_o, pin_oe, osc_run, cpu_tick, per_tick;
  logic                            cpu_rst, bo_irq, lvl;
  logic [7:0]                      pcr;
  wire logic                       pin;
  logic [15:0]                     out_per;
  int                              num_errors = 0;
  int                              num_checks = 0;

  always #50 clk = ~clk;

  cdpm_core dut (.clk(clk), .rst(rst), .user_config_word(cfg), .ctrl(ctl),
    .cpu_divider_reg(div), .power_wr(pwr_wr), .power_wdata(pwr_wd), .bo_detect_pin(bo),
    .por_detect_pin(por), .wdt_overflow(wdt), .wake_irq(wake), .any_irq(anyi),
    .gpio_out(gout), .gpio_oe(goe), .osc_out_pin_o(pin_o), .osc_out_pin_oe(pin_oe),
    .osc_run(osc_run), .cpu_tick(cpu_tick), .periph_tick(per_tick), .cpu_reset(cpu_rst),
    .brownout_irq(bo_irq), .brownout_level_sel(lvl), .power_control_reg(pcr));
  cdpm_far_side far (.clk(clk), .drive_o(pin_o), .drive_oe(pin_oe), .pin(pin),
    .period(out_per));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] v);
    @(posedge clk);
    pwr_wr <= 1'b1;
    pwr_wd <= v;
    @(posedge clk);
    pwr_wr <= 1'b0;
    @(negedge clk);
  endtask
  // cycles between two periph ticks, after a skipped one
  task automatic tick_gap(output int p);
    int k;
    p = 0;
    for (k = 0; k < 3000 && per_tick !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    for (k = 0; k < 3000 && per_tick !== 1'b1; k++) @(negedge clk);
    do begin
      @(negedge clk);
      p++;
    end while (per_tick !== 1'b1 && p < 3000);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_por();
    chk("pcr_rst", 16'h0000, {8'h00, pcr});
    @(posedge clk);
    por <= 1'b1;
    cyc(5);
    @(negedge clk);
    chk("por_flags", 16'h0003, {14'h0, pcr[5:4]});
    wr(8'h30);
    chk("flag_keep", 16'h0003, {14'h0, pcr[5:4]});
    wr(8'h00);
    chk("flag_clr", 16'h0000, {14'h0, pcr[5:4]});
    wr(8'h30);
    chk("flag_noset", 16'h0000, {14'h0, pcr[5:4]});
  endtask
  task automatic t_div();
    int p;
    int e;
    int h;
    int i;
    logic [7:0] ns [3];
    ns = '{8'h00, 8'h01, 8'hFF};
    for (h = 0; h < 2; h++) begin
      for (i = 0; i < 3; i++) begin
        @(posedge clk);
        cfg.compat_clock_halve <= h[0];
        div <= ns[i];
        tick_gap(p);
        tick_gap(p);
        e = (h + 1) * ((ns[i] == 8'h00) ? 1 : 2 * (ns[i] + 1));
        chk("tick_gap", e[15:0], p[15:0]);
      end
    end
    @(posedge clk);
    cfg.compat_clock_halve <= 1'b0;
    div <= 8'h00;
  endtask
  task automatic t_clkout();
    cfg.osc_sel <= cdpm_pkg::CDPM_OSC_RC;
    ctl.clkout_enable <= 1'b1;
    cyc(40);
    @(negedge clk);
    chk("clkout_oe", 16'h0001, {15'h0, pin_oe});
    chk("clkout_per", 16'h0006, out_per);
    @(posedge clk);
    div <= 8'h01;
    cyc(120);
    @(negedge clk);
    chk("clkout_div", 16'h0018, out_per);
    @(posedge clk);
    div <= 8'h00;
    wr(8'h01);
    chk("idle_bit", 16'h0001, {15'h0, pcr[0]});
    cyc(3);
    @(negedge clk);
    chk("idle_cpu", 16'h0000, {15'h0, cpu_tick});
    chk("idle_per", 16'h0001, {15'h0, per_tick});
    cyc(40);
    @(negedge clk);
    chk("idle_out", 16'h0006, out_per);
    @(posedge clk);
    anyi <= 1'b1;
    cyc(3);
    anyi <= 1'b0;
    @(negedge clk);
    chk("idle_exit", 16'h0000, {15'h0, pcr[0]});
    chk("run_cpu", 16'h0001, {15'h0, cpu_tick});
    @(posedge clk);
    cfg.osc_sel <= cdpm_pkg::CDPM_OSC_XTAL;
    @(negedge clk);
    chk("xtal_oe", 16'h0000, {15'h0, pin_oe});
    @(posedge clk);
    cfg.osc_sel <= cdpm_pkg::CDPM_OSC_EXT;
    ctl.clkout_enable <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      gout <= i[0];
      goe <= i[1];
      @(negedge clk);
      chk("gpio_pin", {14'h0, i[1], i[0]}, {14'h0, pin_oe, pin_o});
    end
  endtask
  task automatic t_bo();
    int n;
    chk("bo_lvl", 16'h0001, {15'h0, lvl});
    @(posedge clk);
    bo <= 1'b1;
    cyc(4);
    @(negedge clk);
    chk("bo_rst", 16'h0001, {15'h0, cpu_rst});
    chk("bo_flag", 16'h0001, {15'h0, pcr[5]});
    cyc(30);
    chk("bo_hold", 16'h0001, {15'h0, cpu_rst});
    bo <= 1'b0;
    cyc(4);
    chk("bo_rel", 16'h0000, {15'h0, cpu_rst});
    wr(8'h00);
    n = 0;
    @(posedge clk);
    ctl.brownout_irq_select <= 1'b1;
    bo <= 1'b1;
    repeat (30) begin
      @(negedge clk);
      n += int'(bo_irq === 1'b1);
    end
    chk("irq_once", 16'h0001, n[15:0]);
    chk("irq_norst", 16'h0000, {15'h0, cpu_rst});
    chk("irq_flag", 16'h0001, {15'h0, pcr[5]});
    @(posedge clk);
    bo <= 1'b0;
    wr(8'h00);
    n = 0;
    @(posedge clk);
    ctl.brownout_disable <= 1'b1;
    bo <= 1'b1;
    repeat (10) begin
      @(negedge clk);
      n += int'(bo_irq === 1'b1);
    end
    chk("off_irq", 16'h0000, {15'h0, pcr[5]} | n[15:0]);
    @(posedge clk);
    bo <= 1'b0;
    // keep the detector off until the synchroniser has drained
    cyc(3);
    ctl.brownout_disable <= 1'b0;
  endtask
  task automatic t_down(input int stab, input logic bo_wake);
    int n;
    wr(8'h02);
    chk("down_osc", 16'h0000, {15'h0, osc_run});
    @(posedge clk);
    if (bo_wake) bo <= 1'b1;
    else wake <= 1'b1;
    @(negedge clk);
    n = 0;
    while (pcr[1] !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
      if (n == 4) chk("wake_osc", 16'h0001, {15'h0, osc_run});
    end
    chk("stab_ok", 16'h0001, {15'h0, n >= stab - 2 && n <= stab + 3});
    @(posedge clk);
    wake <= 1'b0;
    bo <= 1'b0;
  endtask
  task automatic t_wdt();
    wr(8'h02);
    @(posedge clk);
    wdt <= 1'b1;
    @(negedge clk);
    chk("wdt_rst", 16'h0001, {15'h0, cpu_rst});
    @(posedge clk);
    wdt <= 1'b0;
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    @(negedge clk);
    chk("rst_exit", 16'h0003, {14'h0, osc_run, ~pcr[1]});
  endtask

  initial begin
    cfg = '{osc_sel: cdpm_pkg::CDPM_OSC_RC, compat_clock_halve: 1'b0, brownout_level: 1'b1};
    ctl = '0;
    cyc(3);
    rst <= 1'b0;
    t_por();
    t_div();
    t_clkout();
    t_bo();
    @(posedge clk);
    cfg.brownout_level <= 1'b0;
    ctl.global_irq_on <= 1'b1;
    ctl.brownout_irq_enable <= 1'b1;
    @(negedge clk);
    chk("bo_lvl0", 16'h0000, {15'h0, lvl});
    t_down(257, 1'b1);
    // let the released detector drain before brownout turns into a reset
    cyc(3);
    ctl.brownout_irq_select <= 1'b0;
    cfg.osc_sel <= cdpm_pkg::CDPM_OSC_XTAL;
    t_down(1025, 1'b0);
    t_wdt();
    end_sim();
  end
  initial begin
    #5_000_000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
